// ### rtl/cycle_timer.sv
// Down-counting timer that flags expiry after a loaded number of cycles
`timescale 1ns/10ps
`default_nettype none
module cycle_timer
#(
    parameter int WIDTH = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic run,
    // Status
    output logic expired
);
    // Remaining cycles
    logic [WIDTH-1:0] count_reg;

    // Load wins over counting; counting holds while run is low
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= '0;
        end
        else if (clk_en)
        begin
            if (load)
            begin
                count_reg <= load_value;
            end
            else if (run && count_reg != '0)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Expiry is a level while the count rests at zero and no load is pending
    assign expired = (count_reg == '0) && !load;
endmodule
`default_nettype wire

// ### rtl/op_mode_fsm.sv
// Operating-mode state machine with power-on configuration capture
//
// Overview of operation
// - Six modes, exactly one active at once.
// - Enter init at power-up and soft reset.
// - Stop mode keeps main regulator enabled.
// - Sleep mode switches main regulator off.
// - Restart after wake or failure; reset controller.
// - Restart returns to normal after reset delay.
// - Critical failure enters fail-safe, regulator off.
// - Fail-safe held until wake or temperature clears.
// - Development mode halts watchdog, modes stay reachable.
// - Test pin low in init selects development.
// - Control and diagnosis via 16-bit serial frames.
// - Host selects mode via mode bits.
// - Mode bits cleared passing through restart.
// - Start in init, watchdog long open window.
// - Capture watchdog/overvoltage behaviour from config pin.
// - Capture development choice from test pin.
// - First frame in init moves to normal.
// - No trigger in long window causes restart.
`timescale 1ns/10ps
`default_nettype none
module op_mode_fsm
    import mode_pkg::*;
#(
    parameter int LONG_WINDOW_CYCLES = LONG_OPEN_WINDOW_CYCLES,
    parameter int TIMER_WIDTH = 24
)
(
    // Clock, power-on reset and clock enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Received serial frame from the frame decoder, same clock
    input wire logic frame_valid,
    input wire logic [FRAME_WIDTH-1:0] frame_data,
    // Watchdog service and failure events, same clock
    input wire logic wd_trigger,
    input wire logic wd_fail,
    // Supply and thermal supervision, same clock
    input wire logic main_regulator_uv,
    input wire logic main_regulator_ov,
    input wire logic overtemp,
    // Wake sources, asynchronous pins
    input wire logic can_wake,
    input wire logic lin_wake,
    input wire logic [2:0] wake_input_pins,
    // Configuration pins, asynchronous
    input wire logic int_cfg_pin,
    input wire logic fail_out3_test_pin,
    // Mode outputs
    output logic [2:0] mode_state,
    output logic [2:0] mode_bits,
    output logic main_regulator_output,
    output logic mcu_reset_n,
    output logic [FRAME_WIDTH-1:0] status_frame,
    // Captured configuration and sticky watchdog failure flag
    output logic cfg_restart_on_fail,
    output logic dev_mode,
    output logic wd_halted,
    output logic wd_fail_flag
);
    //////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    // Synchronised pin levels
    logic int_cfg_s;
    logic test_pin_s;
    logic can_wake_s;
    logic lin_wake_s;
    logic [2:0] wk_s;
    // Raw and synchronised pins, one entry per pin
    logic [6:0] pins_raw;
    logic [6:0] pins_s;

    assign pins_raw = {wake_input_pins, lin_wake, can_wake, fail_out3_test_pin, int_cfg_pin};
    assign {wk_s, lin_wake_s, can_wake_s, test_pin_s, int_cfg_s} = pins_s;

    // One synchroniser per asynchronous pin
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_sync
            pin_sync u_sync
            (
                .clk(clk),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .pin_in(pins_raw[gi]),
                .pin_sync_out(pins_s[gi])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////////
    // State and timers

    // Current mode and next mode
    op_mode_t state_reg;
    op_mode_t state_next;
    // Mode bits as seen by the host
    logic [2:0] mode_bits_reg;
    // Power-on capture done flag
    logic captured_reg;
    // Enabled edges counted while the synchronisers fill
    logic [1:0] settle_reg;
    // Captured configuration
    logic cfg_reg;
    logic dev_reg;
    // Sticky watchdog failure
    logic wd_fail_reg;
    // Timer controls and status
    logic rd_load;
    logic rd_expired;
    logic lw_load;
    logic lw_expired;
    logic lw_run;
    // Combined events
    logic any_wake;
    logic failure;
    logic lw_timeout;
    logic [2:0] req_mode;
    logic host_write;

    assign any_wake = can_wake_s | lin_wake_s | (|wk_s);
    assign req_mode = frame_data[MODE_LSB +: MODE_WIDTH];
    assign host_write = frame_valid && frame_data[WRITE_BIT];

    // Long window runs only in init, and never in development mode
    assign lw_run = (state_reg == MODE_INIT) && !dev_reg;
    assign lw_timeout = lw_run && lw_expired && captured_reg;
    // Watchdog failures count only when the watchdog runs
    assign failure = (wd_fail && !dev_reg) || main_regulator_uv || lw_timeout
        || (main_regulator_ov && captured_reg);

    // Reset delay timer for restart mode
    cycle_timer #(.WIDTH(TIMER_WIDTH)) u_rd_timer
    (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .load(rd_load),
        .load_value(TIMER_WIDTH'(RESET_DELAY_CYCLES)),
        .run(!failure),
        .expired(rd_expired)
    );

    // Long open window timer, armed at power-on
    cycle_timer #(.WIDTH(TIMER_WIDTH)) u_lw_timer
    (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .load(lw_load),
        .load_value(TIMER_WIDTH'(LONG_WINDOW_CYCLES)),
        .run(lw_run),
        .expired(lw_expired)
    );

    // Load the window on every enabled edge until capture; a trigger re-arms it only while the window runs
    assign lw_load = (!captured_reg) || (lw_run && wd_trigger);
    // Restart delay restarts on every cycle spent outside restart
    assign rd_load = (state_reg != MODE_RESTART) || failure;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Power-on configuration capture

    // Sampled once the synchronisers hold real pin levels, then frozen until the next power-on
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            settle_reg <= 2'h0;
            captured_reg <= 1'b0;
            cfg_reg <= CFG_RESET;
            dev_reg <= CFG_RESET;
        end
        else if (clk_en && !captured_reg)
        begin
            // Synchroniser outputs still show their reset level, which would fake a low test pin
            if (settle_reg != SYNC_SETTLE_CYCLES)
            begin
                settle_reg <= settle_reg + 2'h1;
            end
            else
            begin
                captured_reg <= 1'b1;
                cfg_reg <= int_cfg_s;
                dev_reg <= !test_pin_s;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Mode transitions

    // Next-mode decision; failures take priority over host requests
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            MODE_INIT:
            begin
                // Wake events are ignored in init
                if (failure)
                begin
                    state_next = MODE_RESTART;
                end
                else if (frame_valid && captured_reg)
                begin
                    state_next = MODE_NORMAL;
                end
            end
            MODE_NORMAL, MODE_STOP:
            begin
                if (failure)
                begin
                    // Config pin pulled up selects restart, else fail-safe
                    state_next = cfg_reg ? MODE_RESTART : MODE_FAILSAFE;
                end
                else if (host_write)
                begin
                    // Host selection of the next mode
                    unique case (req_mode)
                        REQ_NORMAL: state_next = MODE_NORMAL;
                        REQ_SLEEP: state_next = MODE_SLEEP;
                        REQ_STOP: state_next = MODE_STOP;
                        REQ_RESET: state_next = MODE_INIT;
                        default: state_next = state_reg;
                    endcase
                end
            end
            MODE_SLEEP:
            begin
                if (any_wake)
                begin
                    state_next = MODE_RESTART;
                end
            end
            MODE_RESTART:
            begin
                if (!failure && rd_expired)
                begin
                    state_next = MODE_NORMAL;
                end
            end
            MODE_FAILSAFE:
            begin
                if (any_wake || !overtemp)
                begin
                    state_next = MODE_RESTART;
                end
            end
        endcase
    end

    // Single state register holds exactly one mode
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= MODE_INIT;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Mode bits and sticky watchdog flag

    // Host writes outside init store the mode field; restart clears it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_bits_reg <= MODE_BITS_RESET;
        end
        else if (clk_en)
        begin
            if (state_reg == MODE_RESTART)
            begin
                mode_bits_reg <= MODE_BITS_RESET;
            end
            else if (host_write && state_reg != MODE_INIT)
            begin
                mode_bits_reg <= req_mode;
            end
        end
    end

    // Set on a missed window or reported failure; a write with the clear bit clears, set wins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wd_fail_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (lw_timeout || (wd_fail && !dev_reg))
            begin
                wd_fail_reg <= 1'b1;
            end
            else if (host_write && frame_data[WD_CLEAR_BIT])
            begin
                wd_fail_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Regulator follows mode; microcontroller held in reset during restart
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            main_regulator_output <= 1'b1;
            mcu_reset_n <= 1'b0;
        end
        else if (clk_en)
        begin
            main_regulator_output <= (state_next != MODE_SLEEP)
                && (state_next != MODE_FAILSAFE);
            mcu_reset_n <= (state_next != MODE_RESTART) && captured_reg;
        end
    end

    // 16-bit diagnosis word read back by the host
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_frame <= '0;
        end
        else if (clk_en)
        begin
            status_frame <= {7'h00, wd_fail_reg, dev_reg, cfg_reg, state_reg, mode_bits_reg};
        end
    end

    assign mode_state = state_reg;
    assign mode_bits = mode_bits_reg;
    assign cfg_restart_on_fail = cfg_reg;
    assign dev_mode = dev_reg;
    assign wd_halted = dev_reg;
    assign wd_fail_flag = wd_fail_reg;
endmodule
`default_nettype wire

// ### rtl/pin_sync.sv
// Two-flop synchroniser for an asynchronous pin
`timescale 1ns/10ps
`default_nettype none
module pin_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Pin in, synchronised level out
    input wire logic pin_in,
    output logic pin_sync_out
);
    // First stage, read only by the second stage
    logic meta_reg;

    // Both stages advance together when enabled
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= 1'b0;
            pin_sync_out <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_reg <= pin_in;
            pin_sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### shared/mode_pkg.sv
// Package with mode codes, timing constants and reset values for the operating-mode sequencer
package mode_pkg;
    // Operating modes, Gray coded along init->normal->stop and onward
    typedef enum logic [2:0] {
        MODE_INIT = 3'b000,
        MODE_NORMAL = 3'b001,
        MODE_STOP = 3'b011,
        MODE_SLEEP = 3'b010,
        MODE_RESTART = 3'b110,
        MODE_FAILSAFE = 3'b111
    } op_mode_t;

    // Host-requested mode codes carried in the mode bits of a frame
    localparam logic [2:0] REQ_NORMAL = 3'h0;
    localparam logic [2:0] REQ_SLEEP = 3'h1;
    localparam logic [2:0] REQ_STOP = 3'h2;
    localparam logic [2:0] REQ_RESET = 3'h3;

    // Frame field positions
    localparam int FRAME_WIDTH = 16;
    localparam int MODE_LSB = 0;
    localparam int MODE_WIDTH = 3;
    localparam int WRITE_BIT = 15;
    localparam int WD_CLEAR_BIT = 14;

    // Timing in microseconds and derived cycle counts at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int RESET_DELAY_TIME_US = 10;
    localparam int LONG_OPEN_WINDOW_TIME_US = 200;
    localparam int RESET_DELAY_CYCLES = RESET_DELAY_TIME_US * CLK_MHZ;
    localparam int LONG_OPEN_WINDOW_CYCLES = LONG_OPEN_WINDOW_TIME_US * CLK_MHZ;

    // Reset values
    localparam logic [2:0] MODE_BITS_RESET = 3'h0;
    localparam logic CFG_RESET = 1'b0;
    // Enabled edges after reset before the pin synchronisers show real pin levels
    localparam logic [1:0] SYNC_SETTLE_CYCLES = 2'h2;
endpackage

// ### tb/host_model.sv
// Host controller model issuing 16-bit command frames
`timescale 1ns/10ps
`default_nettype none
module host_model
    import mode_pkg::*;
(
    // Clock
    input wire logic clk,
    // Frame and watchdog service towards the sequencer
    output logic frame_valid,
    output logic [FRAME_WIDTH-1:0] frame_data,
    output logic wd_trigger
);
    initial
    begin
        frame_valid = 1'b0;
        frame_data = 16'h0000;
        wd_trigger = 1'b0;
    end

    // One frame per call; held over its sampling edge only
    task automatic send_word(input logic [FRAME_WIDTH-1:0] word);
        @(posedge clk);
        #1;
        frame_valid = 1'b1;
        frame_data = word;
        wd_trigger = 1'b1;
        @(posedge clk);
        #1;
        // Released data is scrambled so nothing relies on stale bits
        frame_valid = 1'b0;
        frame_data = ~frame_data;
        wd_trigger = 1'b0;
    endtask

    // Write frame carrying a mode request
    task automatic send_frame(input logic [2:0] req);
        send_word({1'b1, 12'h000, req});
    endtask
endmodule
`default_nettype wire

// ### tb/mode_checker_assertions.sv
// Port-level checker for the operating-mode sequencer
`timescale 1ns/10ps
`default_nettype none
module mode_checker
    import mode_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Observed inputs
    input wire logic frame_valid,
    input wire logic wd_fail,
    input wire logic main_regulator_uv,
    // Observed outputs
    input wire logic [2:0] mode_state,
    input wire logic [2:0] mode_bits,
    input wire logic main_regulator_output,
    input wire logic mcu_reset_n,
    input wire logic cfg_restart_on_fail,
    input wire logic dev_mode,
    input wire logic wd_halted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////
    // Edges since reset, saturating; latches capture at the third, so hold is judged from the fifth
    logic [2:0] edge_cnt_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            edge_cnt_reg <= 3'h0;
        end
        else if (edge_cnt_reg != 3'h4)
        begin
            edge_cnt_reg <= edge_cnt_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_one_mode;
        mode_state inside {MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE};
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("mode_state holds no legal mode");
    property p_stop_reg_on;
        mode_state == MODE_STOP |-> main_regulator_output;
    endproperty
    a_stop_reg_on: assert property (p_stop_reg_on) else $error("regulator off in stop");
    property p_sleep_reg_off;
        mode_state == MODE_SLEEP |-> !main_regulator_output;
    endproperty
    a_sleep_reg_off: assert property (p_sleep_reg_off) else $error("regulator on in sleep");
    property p_failsafe_reg_off;
        mode_state == MODE_FAILSAFE |-> !main_regulator_output;
    endproperty
    a_failsafe_reg_off: assert property (p_failsafe_reg_off) else $error("regulator on in fail-safe");
    property p_restart_resets_mcu;
        mode_state == MODE_RESTART |-> !mcu_reset_n;
    endproperty
    a_restart_resets_mcu: assert property (p_restart_resets_mcu) else $error("controller not reset");
    property p_failure_entry;
        (mode_state == MODE_NORMAL && wd_fail && !dev_mode)
            |=> mode_state == (cfg_restart_on_fail ? MODE_RESTART : MODE_FAILSAFE);
    endproperty
    a_failure_entry: assert property (p_failure_entry) else $error("wrong mode after failure");
    property p_first_frame;
        (mode_state == MODE_INIT && frame_valid && mcu_reset_n && !wd_fail && !main_regulator_uv)
            |=> mode_state == MODE_NORMAL;
    endproperty
    a_first_frame: assert property (p_first_frame) else $error("frame in init did not give normal");
    property p_bits_cleared;
        (mode_state == MODE_NORMAL && $past(mode_state) == MODE_RESTART) |-> mode_bits == MODE_BITS_RESET;
    endproperty
    a_bits_cleared: assert property (p_bits_cleared) else $error("mode bits kept over restart");
    property p_latch_hold;
        edge_cnt_reg == 3'h4 |-> $stable(dev_mode) && $stable(cfg_restart_on_fail);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("power-on latch changed");
    property p_dev_halts_wd;
        dev_mode |-> wd_halted;
    endproperty
    a_dev_halts_wd: assert property (p_dev_halts_wd) else $error("watchdog runs in development");
endmodule

bind op_mode_fsm mode_checker mode_checker_i (.clk(clk), .reset_n(reset_n), .frame_valid(frame_valid),
    .wd_fail(wd_fail), .main_regulator_uv(main_regulator_uv), .mode_state(mode_state), .mode_bits(mode_bits),
    .main_regulator_output(main_regulator_output), .mcu_reset_n(mcu_reset_n),
    .cfg_restart_on_fail(cfg_restart_on_fail), .dev_mode(dev_mode), .wd_halted(wd_halted));
`default_nettype wire

// ### tb/tb_op_mode_fsm.sv
// Testbench for the operating-mode sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_op_mode_fsm;
    import mode_pkg::*;
    // Short long-window keeps the run brief
    localparam int LW = 50;
    logic clk, reset_n, wd_fail, overtemp, can_wake, int_cfg_pin, fail_out3_test_pin;
    logic frame_valid, wd_trigger, main_regulator_output, mcu_reset_n, cfg_restart_on_fail, dev_mode, wd_halted;
    logic clk_en, wd_fail_flag;
    logic [FRAME_WIDTH-1:0] frame_data, status_frame;
    logic [2:0] mode_state, mode_bits;
    int failures, n_checks, n;

    op_mode_fsm #(.LONG_WINDOW_CYCLES(LW)) op_mode_fsm_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .frame_valid(frame_valid), .frame_data(frame_data), .wd_trigger(wd_trigger), .wd_fail(wd_fail),
        .main_regulator_uv(1'b0), .main_regulator_ov(1'b0), .overtemp(overtemp), .can_wake(can_wake),
        .lin_wake(1'b0), .wake_input_pins(3'h0), .int_cfg_pin(int_cfg_pin),
        .fail_out3_test_pin(fail_out3_test_pin), .mode_state(mode_state), .mode_bits(mode_bits),
        .main_regulator_output(main_regulator_output), .mcu_reset_n(mcu_reset_n), .status_frame(status_frame),
        .cfg_restart_on_fail(cfg_restart_on_fail), .dev_mode(dev_mode), .wd_halted(wd_halted),
        .wd_fail_flag(wd_fail_flag));
    host_model host_model_i (.clk(clk), .frame_valid(frame_valid), .frame_data(frame_data),
        .wd_trigger(wd_trigger));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for a mode; reports how many cycles it took
    task automatic wait_mode(input logic [2:0] exp, input int max);
        n = 0;
        while (mode_state !== exp && n < max)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("mode_state", exp, mode_state);
    endtask

    task automatic pulse_fail();
        @(posedge clk);
        #1 wd_fail = 1'b1;
        @(posedge clk);
        #1 wd_fail = 1'b0;
    endtask

    // Power-on with pins stable well before release
    task automatic power_up(input logic test, input logic cfg);
        reset_n = 1'b0;
        fail_out3_test_pin = test;
        int_cfg_pin = cfg;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        check("mode_state", MODE_INIT, mode_state);
        check("regulator", 3'h1, 3'(main_regulator_output));
        repeat (3) @(posedge clk);
        #1;
        check("dev_mode", 3'(!test), 3'(dev_mode));
        check("cfg", 3'(cfg), 3'(cfg_restart_on_fail));
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic test_modes();
        power_up(1'b1, 1'b1);
        host_model_i.send_frame(REQ_STOP);
        wait_mode(MODE_NORMAL, 2);
        host_model_i.send_frame(REQ_STOP);
        wait_mode(MODE_STOP, 2);
        check("regulator", 3'h1, 3'(main_regulator_output));
        host_model_i.send_frame(REQ_NORMAL);
        wait_mode(MODE_NORMAL, 2);
        host_model_i.send_frame(REQ_SLEEP);
        wait_mode(MODE_SLEEP, 2);
        check("regulator", 3'h0, 3'(main_regulator_output));
        can_wake = 1'b1;
        wait_mode(MODE_RESTART, 5);
        check("mcu_reset_n", 3'h0, 3'(mcu_reset_n));
        can_wake = 1'b0;
        wait_mode(MODE_NORMAL, RESET_DELAY_CYCLES + 20);
        check("restart long", 3'h1, 3'(n > RESET_DELAY_CYCLES - 10));
        check("mode_bits", MODE_BITS_RESET, mode_bits);
        host_model_i.send_frame(REQ_RESET);
        wait_mode(MODE_INIT, 2);
        wait_mode(MODE_RESTART, LW + 20);
        check("window long", 3'h1, 3'(n > LW - 10));
        wait_mode(MODE_NORMAL, RESET_DELAY_CYCLES + 20);
        check("wd_fail_flag", 3'h1, 3'(wd_fail_flag));
        // Write frame with the flag-clear bit set
        host_model_i.send_word(16'hc000);
        check("wd_fail_flag", 3'h0, 3'(wd_fail_flag));
        $display("test_modes done");
    endtask

    task automatic test_failsafe();
        power_up(1'b1, 1'b0);
        host_model_i.send_frame(REQ_NORMAL);
        wait_mode(MODE_NORMAL, 2);
        overtemp = 1'b1;
        pulse_fail();
        wait_mode(MODE_FAILSAFE, 3);
        check("regulator", 3'h0, 3'(main_regulator_output));
        repeat (30) @(posedge clk);
        #1;
        check("mode_state", MODE_FAILSAFE, mode_state);
        check("status mode", MODE_FAILSAFE, status_frame[5:3]);
        check("status wd flag", 3'h1, 3'(status_frame[8]));
        // Temperature clears while frozen: nothing may move until the enable returns
        clk_en = 1'b0;
        overtemp = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("frozen mode", MODE_FAILSAFE, mode_state);
        clk_en = 1'b1;
        wait_mode(MODE_RESTART, 5);
        wait_mode(MODE_NORMAL, RESET_DELAY_CYCLES + 20);
        $display("test_failsafe done");
    endtask

    task automatic test_dev();
        power_up(1'b0, 1'b1);
        check("wd_halted", 3'h1, 3'(wd_halted));
        repeat (LW + 20) @(posedge clk);
        #1;
        check("mode_state", MODE_INIT, mode_state);
        host_model_i.send_frame(REQ_NORMAL);
        wait_mode(MODE_NORMAL, 2);
        pulse_fail();
        repeat (3) @(posedge clk);
        #1;
        check("mode_state", MODE_NORMAL, mode_state);
        $display("test_dev done");
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        failures = 0;
        n_checks = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        wd_fail = 1'b0;
        overtemp = 1'b0;
        can_wake = 1'b0;
        int_cfg_pin = 1'b1;
        fail_out3_test_pin = 1'b1;
        test_modes();
        test_failsafe();
        test_dev();
        finish_test();
    end

    // Whole run needs about 3300 cycles
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
